// file: design/csw_pkg.sv
// csw_pkg: shared constants and types of the system clock select switch
package csw_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_CFG       = 8'h04;
    localparam logic [7:0] ADDR_STAT      = 8'h08;
    localparam int         SEL_BIT        = 0;
    localparam int         CFG_MODE_LSB   = 0;
    localparam int         CFG_SWEN_N_BIT = 3;
    localparam int         CFG_SECEN_BIT  = 4;
    localparam int         STAT_RUN_BIT   = 0;
    localparam int         STAT_MULT_BIT  = 1;
    localparam int         STAT_HOLD_BIT  = 2;
    localparam int         STAT_SRC_BIT   = 3;
    localparam int         STAT_ST_LSB    = 4;
    localparam logic [2:0] CFG_MODE_RST   = 3'h2;
    localparam logic       CFG_SWEN_N_RST = 1'b1;
    localparam logic       CFG_SECEN_RST  = 1'b0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ==========================================================
    // oscillator modes and switch states
    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE       = 3'h0,
        CRYSTAL_RESONATOR_MODE       = 3'h1,
        HIGH_SPEED_CRYSTAL_MODE      = 3'h2,
        HIGH_SPEED_MULTIPLIER_MODE   = 3'h3,
        RESISTOR_CAPACITOR_MODE      = 3'h4,
        RESISTOR_CAPACITOR_GPIO_MODE = 3'h5,
        EXTERNAL_CLOCK_MODE          = 3'h6,
        EXTERNAL_CLOCK_GPIO_MODE     = 3'h7
    } csw_mode_t;

    typedef enum logic [2:0] {
        ST_RUN_PRI  = 3'h0,
        ST_SYNC_SEC = 3'h1,
        ST_RUN_SEC  = 3'h3,
        ST_OST      = 3'h2,
        ST_PLL      = 3'h6,
        ST_SYNC_PRI = 3'h7,
        ST_SLEEP    = 3'h5
    } csw_state_t;

    // ==========================================================
    // timing
    localparam int CLK_HZ      = 100_000_000;
    localparam int SYNC_EDGES  = 8;
    localparam int OST_EDGES   = 1024;
    localparam int MULTIPLIER_LOCK_DELAY_MS     = 2;
    localparam int MULTIPLIER_LOCK_DELAY_CYCLES = MULTIPLIER_LOCK_DELAY_MS * (CLK_HZ / 1000);
endpackage : csw_pkg

// file: design/csw_clock_switch.sv
// csw_clock_switch: clock source select, startup waits and register slave
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - three config bits pick one of eight modes
// - rc and ext clock drive fosc/4 out
// - port-pin modes make pin a port bit
// - ext clock: no inverter, no startup wait
// - multiplier output forms the internal clock
// - multiplier on only in multiplier mode
// - core held until multiplier lock expires
// - switching allowed only when enable bit zero
// - select bit zero primary, one secondary
// - select bit cleared on every reset
// - select writes ignored unless both enables
// - control bits seven to one read zero
// - count eight destination edges, no glitch
// - freeze at first phase going to secondary, resume after eight
// - crystal return waits startup time too
// - multiplier return adds lock time
// - rc/ext return waits eight primary edges
// - sleep stops clocks, oscillator, holds core
// - wake on reset, watchdog or interrupt
// - sleep pin states per mode
// - startup wait 1024 primary input edges
module csw_clock_switch #(
    parameter int MULTIPLIER_LOCK_DELAY_CYCLES = csw_pkg::MULTIPLIER_LOCK_DELAY_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // clock sources
    input  wire logic        primary_clock_input_pin,
    input  wire logic        multiplier_clk,
    input  wire logic        secondary_clk,
    // core and reset side
    input  wire logic        pwrt_done,
    input  wire logic        first_clock_phase,
    input  wire logic        sleep_req,
    input  wire logic        wake_req,
    output logic             sys_clk_out,
    output logic             core_hold,
    output logic             mult_en,
    output logic             osc_run,
    output logic             fb_inv_en,
    // second oscillator pin and port bit
    input  wire logic        port_a_bit_six_out,
    input  wire logic        port_a_bit_six_oe_n,
    output logic             port_a_bit_six_in,
    input  wire logic        second_oscillator_pin_i,
    output logic             second_oscillator_pin_o,
    output logic             second_oscillator_pin_oe_n
);

    // ==========================================================
    // helpers
    function automatic logic is_xtal(input logic [2:0] m);
        is_xtal = m <= csw_pkg::HIGH_SPEED_MULTIPLIER_MODE;
    endfunction : is_xtal

    function automatic logic is_gpio(input logic [2:0] m);
        is_gpio = (m == csw_pkg::RESISTOR_CAPACITOR_GPIO_MODE)
               || (m == csw_pkg::EXTERNAL_CLOCK_GPIO_MODE);
    endfunction : is_gpio

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == csw_pkg::ADDR_CTRL) || (a == csw_pkg::ADDR_CFG)
               || (a == csw_pkg::ADDR_STAT);
    endfunction : addr_ok

    csw_pkg::csw_state_t state;
    csw_pkg::csw_state_t next_state;
    logic [2:0]          mode;
    logic                swen_n;
    logic                secen;
    logic                sel;
    logic [17:0]         cnt;
    logic [1:0]          div_cnt;
    logic                in_q;
    logic                src_q;
    logic                sec_q;
    logic                src_sec;
    logic                rd_ctrl;
    logic                next_hold;
    logic                pri_src;
    logic                in_rise;
    logic                src_rise;
    logic                sec_rise;
    logic                sel_ok;
    logic                wr_go;
    logic                rd_go;
    logic                run_osc;

    assign pri_src  = mult_en ? multiplier_clk : primary_clock_input_pin;
    assign in_rise  = primary_clock_input_pin & ~in_q;
    assign src_rise = pri_src & ~src_q;
    assign sec_rise = secondary_clk & ~sec_q;
    assign sel_ok   = ~swen_n & secen;
    assign run_osc  = (next_state != csw_pkg::ST_SLEEP) && (next_state != csw_pkg::ST_RUN_SEC);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_q  <= 1'b0;
            src_q <= 1'b0;
            sec_q <= 1'b0;
        end else begin
            in_q  <= primary_clock_input_pin;
            src_q <= pri_src;
            sec_q <= secondary_clk;
        end
    end

    // ==========================================================
    // register slave
    // address and data are taken together in one cycle
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel <= 1'b0;
        end else if (!sel_ok) begin
            sel <= 1'b0;
        end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == csw_pkg::ADDR_CTRL) begin
            sel <= s_axi_wdata[csw_pkg::SEL_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode   <= csw_pkg::CFG_MODE_RST;
            swen_n <= csw_pkg::CFG_SWEN_N_RST;
            secen  <= csw_pkg::CFG_SECEN_RST;
        end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == csw_pkg::ADDR_CFG) begin
            mode   <= s_axi_wdata[csw_pkg::CFG_MODE_LSB +: 3];
            swen_n <= s_axi_wdata[csw_pkg::CFG_SWEN_N_BIT];
            secen  <= s_axi_wdata[csw_pkg::CFG_SECEN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= csw_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok(s_axi_awaddr) ? csw_pkg::RESP_OKAY : csw_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= csw_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            rd_ctrl      <= 1'b0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_ok(s_axi_araddr) ? csw_pkg::RESP_OKAY : csw_pkg::RESP_SLVERR;
            rd_ctrl      <= s_axi_araddr == csw_pkg::ADDR_CTRL;
            case (s_axi_araddr)
                csw_pkg::ADDR_CTRL: begin
                    s_axi_rdata <= 32'(sel);
                end
                csw_pkg::ADDR_CFG: begin
                    s_axi_rdata <= 32'({secen, swen_n, mode});
                end
                csw_pkg::ADDR_STAT: begin
                    s_axi_rdata <= 32'({state, src_sec, core_hold, mult_en, osc_run});
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // switch sequencer
    always_comb begin
        next_state = state;
        case (state)
            csw_pkg::ST_OST: begin
                // no startup wait outside the crystal modes
                if (!is_xtal(mode)) begin
                    next_state = csw_pkg::ST_SYNC_PRI;
                end else if (pwrt_done && in_rise
                             && cnt == 18'(csw_pkg::OST_EDGES - 1)) begin
                    next_state = (mode == csw_pkg::HIGH_SPEED_MULTIPLIER_MODE)
                               ? csw_pkg::ST_PLL : csw_pkg::ST_SYNC_PRI;
                end
            end
            csw_pkg::ST_PLL: begin
                if (cnt == 18'(MULTIPLIER_LOCK_DELAY_CYCLES - 1)) begin
                    next_state = csw_pkg::ST_SYNC_PRI;
                end
            end
            csw_pkg::ST_SYNC_PRI: begin
                if (src_rise && cnt == 18'(csw_pkg::SYNC_EDGES - 1)) begin
                    next_state = csw_pkg::ST_RUN_PRI;
                end
            end
            csw_pkg::ST_RUN_PRI: begin
                if (sleep_req) begin
                    next_state = csw_pkg::ST_SLEEP;
                end else if (sel && first_clock_phase) begin
                    next_state = csw_pkg::ST_SYNC_SEC;
                end
            end
            csw_pkg::ST_SYNC_SEC: begin
                if (sec_rise && cnt == 18'(csw_pkg::SYNC_EDGES - 1)) begin
                    next_state = csw_pkg::ST_RUN_SEC;
                end
            end
            csw_pkg::ST_RUN_SEC: begin
                if (sleep_req) begin
                    next_state = csw_pkg::ST_SLEEP;
                end else if (!sel) begin
                    next_state = csw_pkg::ST_OST;
                end
            end
            csw_pkg::ST_SLEEP: begin
                if (wake_req) begin
                    next_state = sel ? csw_pkg::ST_SYNC_SEC : csw_pkg::ST_OST;
                end
            end
            default: begin
                next_state = csw_pkg::ST_OST;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= csw_pkg::ST_OST;
        end else begin
            state <= next_state;
        end
    end

    // edges are counted on the already registered select, so the
    // destination count never starts on a half-written value
    always_ff @(posedge aclk) begin
        if (!aresetn || next_state != state) begin
            cnt <= 18'h0_0000;
        end else begin
            case (state)
                csw_pkg::ST_OST: begin
                    if (pwrt_done && in_rise) begin
                        cnt <= 18'(cnt + 1);
                    end
                end
                csw_pkg::ST_PLL: begin
                    cnt <= 18'(cnt + 1);
                end
                csw_pkg::ST_SYNC_PRI: begin
                    if (src_rise) begin
                        cnt <= 18'(cnt + 1);
                    end
                end
                csw_pkg::ST_SYNC_SEC: begin
                    if (sec_rise) begin
                        cnt <= 18'(cnt + 1);
                    end
                end
                default: begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    // ==========================================================
    // clock mux and core hold
    // the source flips only with both inputs low, so no pulse can be
    // shorter than the shorter of the two; the cost is a wait of up to
    // one slow half period after the count ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sec <= 1'b0;
        end else if (!pri_src && !secondary_clk) begin
            src_sec <= state == csw_pkg::ST_RUN_SEC;
        end
    end

    always_comb begin
        next_hold = 1'b1;
        if (next_state == csw_pkg::ST_RUN_PRI) begin
            next_hold = src_sec;
        end else if (next_state == csw_pkg::ST_RUN_SEC) begin
            next_hold = ~src_sec;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_hold   <= 1'b1;
            sys_clk_out <= 1'b0;
        end else begin
            core_hold   <= next_hold;
            sys_clk_out <= (state != csw_pkg::ST_SLEEP)
                         & (src_sec ? secondary_clk : pri_src);
        end
    end

    // ==========================================================
    // oscillator controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_run   <= 1'b1;
            mult_en   <= 1'b0;
            fb_inv_en <= 1'b0;
        end else begin
            osc_run   <= run_osc;
            mult_en   <= run_osc && mode == csw_pkg::HIGH_SPEED_MULTIPLIER_MODE;
            fb_inv_en <= run_osc && is_xtal(mode);
        end
    end

    // ==========================================================
    // second oscillator pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 2'h0;
        end else if (in_rise) begin
            div_cnt <= 2'(div_cnt + 1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_oscillator_pin_o    <= 1'b0;
            second_oscillator_pin_oe_n <= 1'b1;
            port_a_bit_six_in          <= 1'b0;
        end else begin
            port_a_bit_six_in <= second_oscillator_pin_i;
            if (is_gpio(mode)) begin
                second_oscillator_pin_o    <= port_a_bit_six_out;
                second_oscillator_pin_oe_n <= port_a_bit_six_oe_n;
            end else if (is_xtal(mode)) begin
                // crystal pin belongs to the analog oscillator
                second_oscillator_pin_o    <= 1'b0;
                second_oscillator_pin_oe_n <= 1'b1;
            end else begin
                second_oscillator_pin_o    <= (state != csw_pkg::ST_SLEEP) & div_cnt[1];
                second_oscillator_pin_oe_n <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sec_done;
        state == csw_pkg::ST_SYNC_SEC ##1 state == csw_pkg::ST_RUN_SEC;
    endsequence

    sequence s_pri_done;
        state == csw_pkg::ST_SYNC_PRI ##1 state == csw_pkg::ST_RUN_PRI;
    endsequence

    a_sel_forced_clear: assert property (!sel_ok |=> !sel)
        else $error("select bit set while switching disabled");
    a_ctrl_read_zero: assert property (s_axi_rvalid && rd_ctrl |-> s_axi_rdata[31:1] == 31'h0)
        else $error("control read shows nonzero upper bits");
    a_mult_only_mode: assert property (mult_en |-> $past(mode) == csw_pkg::HIGH_SPEED_MULTIPLIER_MODE)
        else $error("multiplier on in wrong mode");
    a_sec_eight_edges: assert property (s_sec_done |-> $past(cnt, 1) == 18'h7 && $past(sec_rise, 1))
        else $error("secondary sync left early");
    a_pri_eight_edges: assert property (s_pri_done |-> $past(cnt, 1) == 18'h7 && $past(src_rise, 1))
        else $error("primary sync left early");
    a_ost_full_wait: assert property ($fell(state == csw_pkg::ST_OST) && $past(is_xtal(mode)) |-> $past(cnt) == 18'(csw_pkg::OST_EDGES - 1))
        else $error("startup wait cut short");
    a_pll_lock_wait: assert property ($fell(state == csw_pkg::ST_PLL) |-> $past(cnt) == 18'(MULTIPLIER_LOCK_DELAY_CYCLES - 1))
        else $error("lock wait cut short");
    a_hold_during_lock: assert property (state == csw_pkg::ST_PLL [*2] |-> core_hold)
        else $error("core runs before lock");
    a_sleep_quiet: assert property (state == csw_pkg::ST_SLEEP [*2] |-> !osc_run && !sys_clk_out && !fb_inv_en)
        else $error("clocks running in sleep");
    a_mux_both_low: assert property ($changed(src_sec) |-> !$past(pri_src) && !$past(secondary_clk))
        else $error("mux switched with a clock high");
    a_freeze_at_phase: assert property ($past(state) == csw_pkg::ST_RUN_PRI && state == csw_pkg::ST_SYNC_SEC |-> $past(first_clock_phase))
        else $error("freeze not at first phase");

endmodule : csw_clock_switch

// file: verification/csw_osc_model.sv
// csw_osc_model: primary, multiplier and secondary oscillators seen by the switch
`timescale 1ns/1ps
module csw_osc_model (
    // clock and oscillator controls
    input  wire logic aclk,
    input  wire logic run,
    input  wire logic mul_on,
    // oscillator levels
    output logic      pri,
    output logic      mul,
    output logic      sec
);
    logic [2:0] div = 3'h0;

    // ==========================================================
    // free divider; the secondary runs all the time
    always_ff @(posedge aclk) begin
        div <= div + 3'h1;
    end

    // a stopped oscillator sits low, so no stale edge can reach the switch
    assign pri = run & div[1];
    assign mul = mul_on & div[0];
    assign sec = div[2];
endmodule : csw_osc_model

// file: verification/csw_clock_switch_tb.sv
// csw_clock_switch_tb: scenario testbench of the clock select switch
`timescale 1ns/1ps
module csw_clock_switch_tb;
    logic        aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdd;
    logic [1:0]  bresp, rresp;
    logic        pri, mul, sec, fcp, slp, wak, sco, hold, men, orun, fb;
    logic        pout, poe_n, pin_in, opin_i, opin_o, opin_oe_n, pwd;
    int          n_mismatch = 0;
    int          checks = 0;

    csw_clock_switch #(.MULTIPLIER_LOCK_DELAY_CYCLES(2000)) u_csw_clock_switch (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .primary_clock_input_pin(pri), .multiplier_clk(mul), .secondary_clk(sec),
        .pwrt_done(pwd), .first_clock_phase(fcp), .sleep_req(slp), .wake_req(wak),
        .sys_clk_out(sco), .core_hold(hold), .mult_en(men), .osc_run(orun),
        .fb_inv_en(fb), .port_a_bit_six_out(pout), .port_a_bit_six_oe_n(poe_n),
        .port_a_bit_six_in(pin_in), .second_oscillator_pin_i(opin_i),
        .second_oscillator_pin_o(opin_o), .second_oscillator_pin_oe_n(opin_oe_n));
    csw_osc_model u_csw_osc_model (.aclk(aclk), .run(orun), .mul_on(men), .pri(pri),
        .mul(mul), .sec(sec));

    // ==========================================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do @(posedge aclk); while (awr !== 1'b1);
        awv <= 1'b0; wv <= 1'b0;
        do @(posedge aclk); while (bv !== 1'b1);
        r = bresp;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        d = rdd; r = rresp;
    endtask : rd
    task pulse_phase();
        fcp <= 1'b1;
        @(posedge aclk);
        fcp <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : pulse_phase
    // counts cycles until the core is released; the watchdog bounds it
    task wait_run(output int n);
        n = 0;
        while (hold !== 1'b0) begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_run

    // ==========================================================
    // scenarios
    task t_reset();
        logic [31:0] d; logic [1:0] r; int n;
        rd(csw_pkg::ADDR_CTRL, d, r); chk(d, 0);
        rd(csw_pkg::ADDR_CFG, d, r); chk(d, 32'h0000_000a);
        rd(csw_pkg::ADDR_STAT, d, r); chk(d[2], 1);
        rd(8'h0c, d, r); chk(r, csw_pkg::RESP_SLVERR);
        chk(d, 0);
        wr(8'h0c, 32'h0000_0001, r); chk(r, csw_pkg::RESP_SLVERR);
        wait_run(n); chk(n > 4000, 1);
    endtask : t_reset
    task t_lock();
        logic [31:0] d; logic [1:0] r;
        // secondary enabled but switching locked: only the lock bit stops the write
        wr(csw_pkg::ADDR_CFG, 32'h0000_001a, r);
        wr(csw_pkg::ADDR_CTRL, 32'h0000_0001, r);
        rd(csw_pkg::ADDR_CTRL, d, r); chk(d, 0);
        wr(csw_pkg::ADDR_CFG, 32'h0000_0002, r);
        wr(csw_pkg::ADDR_CTRL, 32'h0000_0001, r);
        rd(csw_pkg::ADDR_CTRL, d, r); chk(d, 0);
        wr(csw_pkg::ADDR_CFG, 32'h0000_0012, r);
        wr(csw_pkg::ADDR_CTRL, 32'h0000_00ff, r);
        rd(csw_pkg::ADDR_CTRL, d, r); chk(d, 32'h0000_0001);
    endtask : t_lock
    task t_trip(input logic [2:0] m);
        logic [31:0] d; logic [1:0] r; int n; int ch; logic last; int cs; logic lsc;
        wr(csw_pkg::ADDR_CFG, {27'h0, 2'b10, m}, r);
        repeat (8) @(posedge aclk);
        chk(opin_oe_n, !(m == 3'h4 || m == 3'h6));
        if (m == 3'h4 || m == 3'h6) begin
            ch = 0;
            cs = 0;
            last = opin_o;
            lsc = sco;
            repeat (32) begin
                @(posedge aclk);
                ch += int'(opin_o !== last);
                cs += int'(sco !== lsc);
                last = opin_o;
                lsc = sco;
            end
            chk(ch, 4);
            chk(cs, 16);
        end
        if (m < 3'h4 || m > 3'h5) chk(fb, m < 3'h4);
        wr(csw_pkg::ADDR_CTRL, 32'h0000_0001, r);
        pulse_phase(); chk(hold, 1);
        wait_run(n); chk(n >= 56 && n < 100, 1);
        rd(csw_pkg::ADDR_STAT, d, r); chk(d[6:3], {csw_pkg::ST_RUN_SEC, 1'b1});
        wr(csw_pkg::ADDR_CTRL, 32'h0000_0000, r);
        pulse_phase(); chk(hold, 1);
        wait_run(n);
        if (m == 3'h3) chk(n >= 6000, 1);
        else if (m < 3'h3) chk(n > 4000, 1);
        else chk(n >= 24 && n < 200, 1);
        chk(men, m == 3'h3);
    endtask : t_trip
    task t_sleep();
        logic [1:0] r; int n;
        wr(csw_pkg::ADDR_CFG, 32'h0000_0014, r);
        slp <= 1'b1;
        @(posedge aclk);
        slp <= 1'b0;
        repeat (8) @(posedge aclk);
        chk({orun, sco, hold, opin_o, opin_oe_n}, 5'b00100);
        wak <= 1'b1;
        @(posedge aclk);
        wak <= 1'b0;
        wait_run(n); chk(orun, 1);
    endtask : t_sleep
    task t_gpio();
        logic [1:0] r; int n;
        wr(csw_pkg::ADDR_CFG, 32'h0000_0015, r);
        poe_n <= 1'b0; pout <= 1'b1; opin_i <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({opin_oe_n, opin_o, pin_in}, 3'b011);
        opin_i <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(pin_in, 0);
        slp <= 1'b1;
        @(posedge aclk);
        slp <= 1'b0;
        repeat (4) @(posedge aclk);
        chk({opin_oe_n, opin_o}, 2'b01);
        wak <= 1'b1;
        @(posedge aclk);
        wak <= 1'b0;
        wait_run(n);
    endtask : t_gpio
    // reset in mid-run with the select set and the power-up timer still busy
    task t_rst_mid();
        logic [31:0] d; logic [1:0] r; int n;
        wr(csw_pkg::ADDR_CTRL, 32'h0000_0001, r);
        rd(csw_pkg::ADDR_CTRL, d, r); chk(d, 32'h0000_0001);
        pwd <= 1'b0;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(csw_pkg::ADDR_CTRL, d, r); chk(d, 0);
        rd(csw_pkg::ADDR_CFG, d, r); chk(d, 32'h0000_000a);
        // no startup edge may count while the power-up timer runs
        repeat (200) @(posedge aclk);
        rd(csw_pkg::ADDR_STAT, d, r); chk(d[6:4], csw_pkg::ST_OST);
        pwd <= 1'b1;
        wait_run(n); chk(n > 4000, 1);
    endtask : t_rst_mid

    // ==========================================================
    // clock, sequence and closing
    task conclude();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    // the longest path is six crystal restarts of about 4100 cycles
    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        conclude();
    end
    initial begin
        aresetn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0;
        fcp = 0; slp = 0; wak = 0; pout = 0; poe_n = 1; opin_i = 0; pwd = 1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_lock();
        for (int m = 0; m < 8; m++) t_trip(3'(m));
        t_sleep();
        t_gpio();
        t_rst_mid();
        conclude();
    end
endmodule : csw_clock_switch_tb
